// ===== include/ctu_defs.svh
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH

// ****************************************
// register offsets (word index on the plain register port)
// ****************************************
`define OFS_MAIN_CTRL 4'h0
`define OFS_CURRENT_CTRL 4'h1
`define OFS_EDGE_B_CONFIG 4'h2
`define OFS_EDGE_A_CONFIG 4'h3
`define OFS_IRQ_FLAG 4'h4
`define OFS_IRQ_ENABLE 4'h5

// ****************************************
// main control fields
// ****************************************
`define BIT_UNIT_ENABLE 7
`define BIT_EDGE_INPUTS_ENABLE 3
`define BIT_ORDERED_EDGES 2
`define BIT_SOURCE_DISCHARGE 1
`define BIT_CONV_TRIGGER_ENABLE 0

// ****************************************
// edge channel config fields
// ****************************************
`define BIT_SENSITIVITY 7
`define BIT_POLARITY 6
`define SRC_MSB 5
`define SRC_LSB 2
`define BIT_B_FLAG 1
`define BIT_A_FLAG 0

// ****************************************
// current control fields
// ****************************************
`define TRIM_MSB 7
`define TRIM_LSB 2
`define RANGE_MSB 1
`define RANGE_LSB 0

// ****************************************
// reset values
// ****************************************
`define RESET_BYTE 8'h00
`define RESET_RANGE 2'h0
`define RESET_TRIM 6'h00

`endif

// ===== include/ctu_pkg.sv
package ctu_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [3:0] addr_type;
    typedef logic [15:0] source_vec_type;
endpackage

// ===== include/edge_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface edge_chan_if;
    logic sensitivity;
    logic polarity;
    logic [3:0] source_sel;
    logic [15:0] sources;
    logic event_hit;
    modport ctrl (output sensitivity, polarity, source_sel, sources, input event_hit);
    modport chan (input sensitivity, polarity, source_sel, sources, output event_hit);
endinterface
`default_nettype wire

// ===== hdl/edge_channel.sv
`timescale 1ns/1ps
`default_nettype none
module edge_channel (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // channel config and result
    edge_chan_if.chan ch
);
    import ctu_pkg::*;

    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic prev_reg;
    wire logic sel_level;
    wire logic active_level;
    wire logic active_prev;

    // ****************************************
    // synchronise every source before selection
    // ****************************************
    // selecting after sync avoids a glitch when the source field changes
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_sync
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= ch.sources[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    assign sel_level = sync2_reg[ch.source_sel];
    assign active_level = ch.polarity ? sel_level : ~sel_level;
    assign active_prev = ch.polarity ? prev_reg : ~prev_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sel_level;
        end
    end

    // level mode fires while the level matches, so a config change onto a matching input hits at once
    assign ch.event_hit = ch.sensitivity ? (active_level & ~active_prev) : active_level;
endmodule
`default_nettype wire

// ===== hdl/charge_time_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defs.svh"
module charge_time_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire ctu_pkg::addr_type reg_addr,
    input wire ctu_pkg::byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ctu_pkg::byte_type reg_rdata,
    // edge sources: pins one and two feed both channels, pins a channel a only
    input wire logic edge_pin_one,
    input wire logic edge_pin_two,
    input wire logic [5:0] edge_pins_a,
    // edge sources, channel b
    input wire logic [4:0] edge_pins_b,
    // shared sources
    input wire logic [2:0] comparator_out,
    input wire logic [2:0] capture_compare_trig,
    input wire logic capture_compare_one_irq,
    input wire logic timer_one_irq,
    // analog side
    output logic current_enable,
    output logic source_discharge_out,
    output logic [1:0] current_range_out,
    output logic [5:0] current_trim_out,
    output logic conversion_trigger,
    // interrupt
    output logic irq_request
);
    import ctu_pkg::*;

    // ****************************************
    // register state
    // ****************************************
    logic unit_enable_reg;
    logic edge_inputs_enable_reg;
    logic ordered_edges_enable_reg;
    logic source_discharge_reg;
    logic conversion_trigger_enable_reg;
    logic [1:0] current_range_sel_reg;
    logic [5:0] current_trim_reg;
    logic edge_a_sensitivity_sel_reg;
    logic edge_a_polarity_reg;
    logic [3:0] edge_a_source_sel_reg;
    logic edge_b_sensitivity_sel_reg;
    logic edge_b_polarity_reg;
    logic [3:0] edge_b_source_sel_reg;
    logic edge_a_seen_flag_reg;
    logic edge_b_seen_flag_reg;
    logic irq_flag_reg;
    logic irq_enable_reg;
    logic current_enable_reg;
    logic conversion_trigger_reg;
    byte_type reg_rdata_reg;

    logic edge_a_seen_flag_next;
    logic edge_b_seen_flag_next;
    logic irq_flag_next;

    // ****************************************
    // edge channels
    // ****************************************
    edge_chan_if chan_a ();
    edge_chan_if chan_b ();

    // channel a: 15-13 comparators, 12-10 triggers, 9-4 pins 8..3, 3 pin one, 2 pin two, 1/0 irqs
    assign chan_a.sources = {comparator_out[2], comparator_out[1], comparator_out[0],
                             capture_compare_trig[2], capture_compare_trig[1], capture_compare_trig[0],
                             edge_pins_a[5], edge_pins_a[4], edge_pins_a[3],
                             edge_pins_a[2], edge_pins_a[1], edge_pins_a[0],
                             edge_pin_one, edge_pin_two, capture_compare_one_irq, timer_one_irq};
    // channel b: 15-13 comparators, 12 reserved (tied low, never fires with high polarity), 11-9 triggers, 8-4 pins 13..9
    assign chan_b.sources = {comparator_out[2], comparator_out[1], comparator_out[0], 1'b0,
                             capture_compare_trig[2], capture_compare_trig[1], capture_compare_trig[0],
                             edge_pins_b[4], edge_pins_b[3], edge_pins_b[2],
                             edge_pins_b[1], edge_pins_b[0],
                             edge_pin_one, edge_pin_two, capture_compare_one_irq, timer_one_irq};
    assign chan_a.sensitivity = edge_a_sensitivity_sel_reg;
    assign chan_a.polarity = edge_a_polarity_reg;
    assign chan_a.source_sel = edge_a_source_sel_reg;
    assign chan_b.sensitivity = edge_b_sensitivity_sel_reg;
    assign chan_b.polarity = edge_b_polarity_reg;
    assign chan_b.source_sel = edge_b_source_sel_reg;

    edge_channel u_chan_a (
        .mclk(mclk),
        .rstn(rstn),
        .ch(chan_a.chan)
    );

    edge_channel u_chan_b (
        .mclk(mclk),
        .rstn(rstn),
        .ch(chan_b.chan)
    );

    // ****************************************
    // decode
    // ****************************************
    wire logic wr_main = reg_wr && (reg_addr == `OFS_MAIN_CTRL);
    wire logic wr_current = reg_wr && (reg_addr == `OFS_CURRENT_CTRL);
    wire logic wr_b_cfg = reg_wr && (reg_addr == `OFS_EDGE_B_CONFIG);
    wire logic wr_a_cfg = reg_wr && (reg_addr == `OFS_EDGE_A_CONFIG);
    wire logic wr_irq_flag = reg_wr && (reg_addr == `OFS_IRQ_FLAG);
    wire logic wr_irq_enable = reg_wr && (reg_addr == `OFS_IRQ_ENABLE);

    wire logic edges_live = unit_enable_reg && edge_inputs_enable_reg;
    wire logic hit_a = edges_live && chan_a.event_hit;
    // channel b waits for channel a when ordering is on
    wire logic b_allowed = !ordered_edges_enable_reg || edge_a_seen_flag_reg;
    wire logic hit_b = edges_live && chan_b.event_hit && b_allowed;

    // ****************************************
    // status flags
    // ****************************************
    // a software write loads both flags at once; a hardware hit in that cycle still wins
    always_comb begin
        edge_a_seen_flag_next = edge_a_seen_flag_reg;
        edge_b_seen_flag_next = edge_b_seen_flag_reg;
        if (wr_a_cfg) begin
            edge_a_seen_flag_next = reg_wdata[`BIT_A_FLAG];
            edge_b_seen_flag_next = reg_wdata[`BIT_B_FLAG];
        end
        if (hit_a) begin
            edge_a_seen_flag_next = 1'b1;
        end
        if (hit_b) begin
            edge_b_seen_flag_next = 1'b1;
        end
    end

    wire logic exactly_one = edge_a_seen_flag_next ^ edge_b_seen_flag_next;
    // follow the enable being written, so the source drops in the same cycle as the unit
    wire logic unit_enable_next = wr_main ? reg_wdata[`BIT_UNIT_ENABLE] : unit_enable_reg;
    wire logic current_enable_next = unit_enable_next && exactly_one;
    wire logic source_off_event = current_enable_reg && !current_enable_next;
    // the hit that completes the pair is the second edge, whichever channel it came on
    wire logic second_edge = (hit_a || hit_b) && edge_a_seen_flag_next && edge_b_seen_flag_next &&
        !(edge_a_seen_flag_reg && edge_b_seen_flag_reg);

    always_comb begin
        irq_flag_next = irq_flag_reg;
        if (wr_irq_flag) begin
            irq_flag_next = reg_wdata[0];
        end
        if (source_off_event) begin
            irq_flag_next = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            unit_enable_reg <= 1'b0;
            edge_inputs_enable_reg <= 1'b0;
            ordered_edges_enable_reg <= 1'b0;
            source_discharge_reg <= 1'b0;
            conversion_trigger_enable_reg <= 1'b0;
        end else if (wr_main) begin
            unit_enable_reg <= reg_wdata[`BIT_UNIT_ENABLE];
            edge_inputs_enable_reg <= reg_wdata[`BIT_EDGE_INPUTS_ENABLE];
            ordered_edges_enable_reg <= reg_wdata[`BIT_ORDERED_EDGES];
            source_discharge_reg <= reg_wdata[`BIT_SOURCE_DISCHARGE];
            conversion_trigger_enable_reg <= reg_wdata[`BIT_CONV_TRIGGER_ENABLE];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            current_range_sel_reg <= `RESET_RANGE;
            current_trim_reg <= `RESET_TRIM;
        end else if (wr_current) begin
            current_range_sel_reg <= reg_wdata[`RANGE_MSB:`RANGE_LSB];
            current_trim_reg <= reg_wdata[`TRIM_MSB:`TRIM_LSB];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edge_b_sensitivity_sel_reg <= 1'b0;
            edge_b_polarity_reg <= 1'b0;
            edge_b_source_sel_reg <= 4'h0;
        end else if (wr_b_cfg) begin
            edge_b_sensitivity_sel_reg <= reg_wdata[`BIT_SENSITIVITY];
            edge_b_polarity_reg <= reg_wdata[`BIT_POLARITY];
            edge_b_source_sel_reg <= reg_wdata[`SRC_MSB:`SRC_LSB];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edge_a_sensitivity_sel_reg <= 1'b0;
            edge_a_polarity_reg <= 1'b0;
            edge_a_source_sel_reg <= 4'h0;
        end else if (wr_a_cfg) begin
            edge_a_sensitivity_sel_reg <= reg_wdata[`BIT_SENSITIVITY];
            edge_a_polarity_reg <= reg_wdata[`BIT_POLARITY];
            edge_a_source_sel_reg <= reg_wdata[`SRC_MSB:`SRC_LSB];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edge_a_seen_flag_reg <= 1'b0;
            edge_b_seen_flag_reg <= 1'b0;
            current_enable_reg <= 1'b0;
            conversion_trigger_reg <= 1'b0;
        end else begin
            edge_a_seen_flag_reg <= edge_a_seen_flag_next;
            edge_b_seen_flag_reg <= edge_b_seen_flag_next;
            current_enable_reg <= current_enable_next;
            conversion_trigger_reg <= conversion_trigger_enable_reg && second_edge;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_flag_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
        end else begin
            irq_flag_reg <= irq_flag_next;
            if (wr_irq_enable) begin
                irq_enable_reg <= reg_wdata[0];
            end
        end
    end

    // ****************************************
    // read port
    // ****************************************
    byte_type rd_mux;
    always_comb begin
        case (reg_addr)
            `OFS_MAIN_CTRL: rd_mux = {unit_enable_reg, 3'h0, edge_inputs_enable_reg,
                                      ordered_edges_enable_reg, source_discharge_reg,
                                      conversion_trigger_enable_reg};
            `OFS_CURRENT_CTRL: rd_mux = {current_trim_reg, current_range_sel_reg};
            `OFS_EDGE_B_CONFIG: rd_mux = {edge_b_sensitivity_sel_reg, edge_b_polarity_reg,
                                          edge_b_source_sel_reg, 2'h0};
            `OFS_EDGE_A_CONFIG: rd_mux = {edge_a_sensitivity_sel_reg, edge_a_polarity_reg,
                                          edge_a_source_sel_reg, edge_b_seen_flag_reg,
                                          edge_a_seen_flag_reg};
            `OFS_IRQ_FLAG: rd_mux = {7'h00, irq_flag_reg};
            `OFS_IRQ_ENABLE: rd_mux = {7'h00, irq_enable_reg};
            default: rd_mux = `RESET_BYTE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_reg <= `RESET_BYTE;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_mux;
        end else begin
            reg_rdata_reg <= `RESET_BYTE;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = reg_rdata_reg;
    assign current_enable = current_enable_reg;
    assign source_discharge_out = source_discharge_reg;
    assign current_range_out = current_range_sel_reg;
    assign current_trim_out = current_trim_reg;
    assign conversion_trigger = conversion_trigger_reg;
    assign irq_request = irq_flag_reg && irq_enable_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_source_on;
        current_enable;
    endsequence
    sequence s_source_off;
        !current_enable;
    endsequence

    a_enable_exact_one: assert property (current_enable == (unit_enable_reg &&
        (edge_a_seen_flag_reg ^ edge_b_seen_flag_reg))) else $error("current enable mismatch");
    a_enable_off_equal: assert property ((edge_a_seen_flag_reg == edge_b_seen_flag_reg) |-> !current_enable)
        else $error("current on with equal flags");
    a_irq_on_fall: assert property (s_source_on ##1 s_source_off |-> irq_flag_reg)
        else $error("irq flag not set on source off");
    a_irq_gate: assert property (irq_request == (irq_flag_reg && irq_enable_reg))
        else $error("irq request gating wrong");
    a_irq_sticky: assert property (irq_flag_reg && !(wr_irq_flag && !reg_wdata[0]) |=> irq_flag_reg)
        else $error("irq flag dropped");
    a_disabled_quiet: assert property (!unit_enable_reg |-> !current_enable)
        else $error("current on while unit disabled");
    a_blocked_hold: assert property (!edge_inputs_enable_reg && !wr_a_cfg |=>
        $stable(edge_a_seen_flag_reg) && $stable(edge_b_seen_flag_reg)) else $error("flag moved while blocked");
    a_order_hold: assert property (ordered_edges_enable_reg && !edge_a_seen_flag_reg && !edge_b_seen_flag_reg
        && !wr_a_cfg && !chan_a.event_hit |=> !edge_b_seen_flag_reg) else $error("b flag set before a");
    a_sw_write: assert property (wr_a_cfg && !hit_a && !hit_b |=>
        edge_a_seen_flag_reg == $past(reg_wdata[0])) else $error("flag write lost");
    a_b_low_zero: assert property (reg_rd && reg_addr == `OFS_EDGE_B_CONFIG |=> reg_rdata[1:0] == 2'h0)
        else $error("reserved bits not zero");
    a_hit_a_sets: assert property (hit_a |=> edge_a_seen_flag_reg)
        else $error("a flag not set on hit");
    a_hit_b_sets: assert property (hit_b |=> edge_b_seen_flag_reg)
        else $error("b flag not set on hit");
    a_trig_pair: assert property (conversion_trigger |-> edge_a_seen_flag_reg && edge_b_seen_flag_reg)
        else $error("trigger without both edges");
    a_trig_single: assert property (conversion_trigger |=> !conversion_trigger)
        else $error("trigger longer than one cycle");
endmodule
`default_nettype wire

// ===== tb/edge_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module edge_source_model (
    // clock
    input wire logic mclk,
    // edge pins
    output logic edge_pin_one,
    output logic edge_pin_two,
    output logic [5:0] edge_pins_a,
    output logic [4:0] edge_pins_b,
    // peripheral sources
    output logic [2:0] comparator_out,
    output logic [2:0] capture_compare_trig,
    output logic capture_compare_one_irq,
    output logic timer_one_irq
);
    // ****
    // source levels: bit 0 pin one, 1 pin two, 2-7 pins a, 8-12 pins b,
    // 13-15 comparators, 16-18 triggers, 19 ccp irq, 20 timer irq
    // ****
    logic [20:0] src_reg = 21'h000000;

    // levels move just after an edge, like a clocked peripheral would
    task automatic drive(input logic [20:0] v);
        @(posedge mclk);
        src_reg <= v;
    endtask

    assign edge_pin_one = src_reg[0];
    assign edge_pin_two = src_reg[1];
    assign edge_pins_a = src_reg[7:2];
    assign edge_pins_b = src_reg[12:8];
    assign comparator_out = src_reg[15:13];
    assign capture_compare_trig = src_reg[18:16];
    assign capture_compare_one_irq = src_reg[19];
    assign timer_one_irq = src_reg[20];
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctu_defs.svh"
module tb;
    import ctu_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    addr_type reg_addr = 4'h0;
    byte_type reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    byte_type reg_rdata;
    byte_type rd;
    logic pin1, pin2, ccp_irq, tmr_irq, cur_en, dis, trig, irq;
    logic [5:0] pins_a;
    logic [4:0] pins_b;
    logic [2:0] cmp, ccp;
    logic [1:0] rng;
    logic [5:0] trim;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;

    always #4 mclk = ~mclk;

    charge_time_unit u_charge_time_unit (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .edge_pin_one(pin1), .edge_pin_two(pin2), .edge_pins_a(pins_a), .edge_pins_b(pins_b),
        .comparator_out(cmp), .capture_compare_trig(ccp), .capture_compare_one_irq(ccp_irq),
        .timer_one_irq(tmr_irq), .current_enable(cur_en), .source_discharge_out(dis),
        .current_range_out(rng), .current_trim_out(trim), .conversion_trigger(trig),
        .irq_request(irq));

    edge_source_model u_edge_source_model (.mclk(mclk), .edge_pin_one(pin1), .edge_pin_two(pin2),
        .edge_pins_a(pins_a), .edge_pins_b(pins_b), .comparator_out(cmp),
        .capture_compare_trig(ccp), .capture_compare_one_irq(ccp_irq), .timer_one_irq(tmr_irq));

    // ****
    // bus and checking helpers
    // ****
    task automatic check(input string what, input byte_type exp, input byte_type got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wr(input addr_type a, input byte_type d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic chk_reg(input string what, input addr_type a, input byte_type exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd = reg_rdata;
        check(what, exp, rd);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic src(input logic [20:0] v);
        u_edge_source_model.drive(v);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic int src_index(input logic b, input int code);
        if (code >= 13) return code;
        if (b && code == 12) return -1;
        if (b && code >= 9) return code + 7;
        if (!b && code >= 10) return code + 6;
        if (code >= 4) return b ? code + 4 : code - 2;
        return (code == 3) ? 0 : (code == 2) ? 1 : (code == 1) ? 19 : 20;
    endfunction

    // ****
    // scenarios
    // ****
    task automatic test_regs();
        for (int i = 0; i < 6; i++) chk_reg("reset value", addr_type'(i), 8'h00);
        check("current enable", 8'h00, {7'h0, cur_en});
        wr(`OFS_EDGE_B_CONFIG, 8'hff);
        chk_reg("edge b config", `OFS_EDGE_B_CONFIG, 8'hfc);
        wr(4'h9, 8'hff);
        chk_reg("unmapped", 4'h9, 8'h00);
        wr(`OFS_CURRENT_CTRL, 8'h85);
        wait_cyc(1);
        check("range", 8'h01, {6'h0, rng});
        check("trim", 8'h21, {2'h0, trim});
        wr(`OFS_CURRENT_CTRL, 8'h7e);
        wait_cyc(1);
        check("range", 8'h02, {6'h0, rng});
        check("trim", 8'h1f, {2'h0, trim});
        wr(`OFS_MAIN_CTRL, 8'h02);
        wait_cyc(1);
        check("discharge", 8'h01, {7'h0, dis});
        wr(`OFS_MAIN_CTRL, 8'h00);
        wait_cyc(1);
        check("discharge", 8'h00, {7'h0, dis});
        $display("test registers finished");
    endtask

    task automatic test_soft_flags();
        wr(`OFS_EDGE_B_CONFIG, 8'h00);
        wr(`OFS_MAIN_CTRL, 8'h80);
        wr(`OFS_EDGE_A_CONFIG, 8'h01);
        wait_cyc(1);
        check("current enable", 8'h01, {7'h0, cur_en});
        wr(`OFS_EDGE_A_CONFIG, 8'h03);
        wait_cyc(1);
        check("current enable", 8'h00, {7'h0, cur_en});
        chk_reg("irq flag", `OFS_IRQ_FLAG, 8'h01);
        check("irq request", 8'h00, {7'h0, irq});
        wr(`OFS_IRQ_ENABLE, 8'h01);
        wait_cyc(1);
        check("irq request", 8'h01, {7'h0, irq});
        wr(`OFS_EDGE_A_CONFIG, 8'h00);
        wr(`OFS_EDGE_A_CONFIG, 8'h02);
        wr(`OFS_EDGE_A_CONFIG, 8'h00);
        chk_reg("irq flag", `OFS_IRQ_FLAG, 8'h01);
        wr(`OFS_IRQ_FLAG, 8'h00);
        wait_cyc(1);
        check("irq request", 8'h00, {7'h0, irq});
        wr(`OFS_MAIN_CTRL, 8'h00);
        wr(`OFS_EDGE_A_CONFIG, 8'h01);
        wait_cyc(2);
        check("current enable", 8'h00, {7'h0, cur_en});
        wr(`OFS_EDGE_A_CONFIG, 8'h00);
        wr(`OFS_IRQ_FLAG, 8'h00);
        $display("test software flags finished");
    endtask

    task automatic test_hw_edges();
        logic seen;
        wr(`OFS_EDGE_B_CONFIG, 8'hc8);
        wr(`OFS_EDGE_A_CONFIG, 8'hcc);
        wr(`OFS_MAIN_CTRL, 8'h89);
        src(21'h000001);
        wait_cyc(1);
        check("current enable", 8'h00, {7'h0, cur_en});
        wait_cyc(5);
        check("current enable", 8'h01, {7'h0, cur_en});
        src(21'h000003);
        seen = 1'b0;
        repeat (8) begin
            @(negedge mclk);
            if (trig === 1'b1) seen = 1'b1;
        end
        check("trigger", 8'h01, {7'h0, seen});
        check("current enable", 8'h00, {7'h0, cur_en});
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcf);
        wr(`OFS_EDGE_A_CONFIG, 8'hcc);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcc);
        src(21'h000000);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcc);
        $display("test hardware edges finished");
    endtask

    task automatic test_ordered();
        wr(`OFS_MAIN_CTRL, 8'h8c);
        src(21'h000002);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcc);
        src(21'h000003);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcd);
        src(21'h000001);
        wait_cyc(4);
        src(21'h000003);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'hcf);
        src(21'h000000);
        wr(`OFS_EDGE_A_CONFIG, 8'hcc);
        $display("test ordered edges finished");
    endtask

    task automatic test_level();
        wr(`OFS_MAIN_CTRL, 8'h80);
        wr(`OFS_EDGE_A_CONFIG, 8'h4c);
        src(21'h000001);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'h4c);
        // drop the polarity before opening the edges, or the old polarity lands a hit first
        wr(`OFS_EDGE_A_CONFIG, 8'h0c);
        wr(`OFS_MAIN_CTRL, 8'h88);
        wait_cyc(6);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'h0c);
        wr(`OFS_EDGE_A_CONFIG, 8'h4c);
        wait_cyc(4);
        chk_reg("flags", `OFS_EDGE_A_CONFIG, 8'h4d);
        src(21'h000000);
        $display("test level mode finished");
    endtask

    task automatic test_source_map(input logic b);
        int idx;
        byte_type cfg;
        logic [20:0] sel;
        wr(`OFS_MAIN_CTRL, 8'h88);
        // park the other channel: reserved code on b never fires; falling timer edge on a fires when sources drop, cleared by the a config write
        wr(b ? `OFS_EDGE_A_CONFIG : `OFS_EDGE_B_CONFIG, b ? 8'h80 : 8'h70);
        for (int code = 0; code < 16; code++) begin
            idx = src_index(b, code);
            sel = (idx >= 0) ? (21'h000001 << idx) : 21'h000000;
            cfg = 8'h40 | byte_type'(code << 2);
            src(21'h000000);
            wait_cyc(4);
            wr(b ? `OFS_EDGE_B_CONFIG : `OFS_EDGE_A_CONFIG, cfg);
            wr(`OFS_EDGE_A_CONFIG, b ? 8'h80 : cfg);
            src(21'h1fffff & ~sel);
            wait_cyc(6);
            chk_reg("others", `OFS_EDGE_A_CONFIG, b ? 8'h80 : cfg);
            check("unselected flag", 8'h00, {7'h0, rd[b ? 1 : 0]});
            src(21'h1fffff);
            wait_cyc(6);
            chk_reg("selected", `OFS_EDGE_A_CONFIG, b ? (8'h80 | {6'h0, idx >= 0, 1'b0}) : (cfg | 8'h01));
            check("selected flag", {7'h0, idx >= 0}, {7'h0, rd[b ? 1 : 0]});
        end
        src(21'h000000);
        $display("test source map finished");
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        test_regs();
        test_soft_flags();
        test_hw_edges();
        test_ordered();
        test_level();
        test_source_map(1'b0);
        test_source_map(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
